// file: protected_page_map.svh
// register offsets, reset values and key codes of the protected page block
`ifndef PROTECTED_PAGE_MAP_SVH
`define PROTECTED_PAGE_MAP_SVH
`define SFR_PORT_DATA 8'he2
`define SFR_PORT_ADDR_HIGH 8'he3
`define SFR_PORT_ADDR_LOW 8'he4
`define SFR_FLASH_MODE 8'he5
`define SFR_COMMAND_KEY 8'he6
`define SFR_FLASH_CONTROL 8'he7
`define PG_IAP_LOW_BOUNDARY 8'h03
`define PG_CLOCK_SOURCE 8'h40
`define PG_CLOCK_DIVIDER 8'h41
`define PG_BROWNOUT 8'h44
`define PG_WRITE_LOCK 8'h48
`define PG_DEVICE 8'h4c
`define KEY_FIRST 8'h46
`define KEY_SECOND 8'hb9
`define MODE_PAGE_WRITE 3'h4
`define MODE_PAGE_READ 3'h5
`define PAGE_ADDR_HIGH 8'h00
`define RST_PORT_DATA 8'hff
`define RST_IAP_LOW_BOUNDARY 7'h3b
`define RST_CLOCK_SOURCE 8'h50
`define RST_CLOCK_DIVIDER 2'h0
`define RST_BROWNOUT 8'h35
`define RST_WRITE_LOCK 8'h00
`define RST_DEVICE 8'h03
`define BIT_ACCESS_ENABLE 7
`define BIT_SOFT_BOOT 6
`define BIT_SOFT_RESET 5
`define BIT_COMMAND_FAIL 4
`define CLOCK_DIV_FIXED 8'h02
`define BROWNOUT_FIXED 8'h01
`define FAST_RC_SETTLE_CYCLES 16'h0c80
`endif

// file: protected_page_pkg.sv
// types of the protected page block
`default_nettype none
package protected_page_pkg;
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_BUSY
	} phase_e;

	typedef struct packed {
		logic por;
		logic ext;
		logic other;
	} reset_cause_s;

	typedef struct packed {
		phase_e phase;
		logic [7:0] port_data;
		logic [7:0] addr_high;
		logic [7:0] addr_low;
		logic [2:0] mode;
		logic access_enable;
		logic soft_boot;
		logic soft_reset;
		logic command_fail;
		logic [6:0] iap_low_boundary;
		logic [7:0] clock_source;
		logic [1:0] system_clock_divider;
		logic [7:0] brownout;
		logic [7:0] write_lock;
		logic [7:0] device;
		logic opt_loaded;
		logic [1:0] flag_meta;
		logic [1:0] flag_sync;
	} state_s;
endpackage : protected_page_pkg
`default_nettype wire

// file: protected_sfr_page_access.sv
// protected page registers reached through the flash access port
`timescale 1ns/1ps
`default_nettype none
`include "protected_page_map.svh"
module protected_sfr_page_access (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_sfr_addr,
	input wire logic i_sfr_we,
	input wire logic [7:0] i_sfr_wdata,
	output logic [7:0] o_sfr_rdata,
	output logic o_cpu_stall,
	output logic o_soft_reset,
	output logic o_soft_boot,
	input wire logic [15:0] i_isp_start,
	output logic [15:0] o_iap_low_addr,
	output logic [15:0] o_iap_high_addr,
	output logic o_iap_bound_error,
	output logic [1:0] o_crystal_gain,
	output logic o_crystal_enable,
	output logic o_port6_xtal_gpio,
	output logic o_fast_rc_enable,
	output logic [1:0] o_master_clock_source,
	output logic o_multiplier_enable,
	output logic [3:0] o_oscillator_select,
	output logic [3:0] o_system_clock_divide,
	input wire logic [1:0] i_opt_detector2_level,
	input wire logic i_detector1_flag,
	input wire logic i_detector2_flag,
	input wire logic i_power_down,
	output logic [1:0] o_detector2_level,
	output logic o_detector2_run,
	output logic o_brownout_reset,
	input wire logic [7:0] i_guarded_write,
	output logic [7:0] o_guarded_write_allow,
	input wire logic i_fetch_valid,
	input wire logic [15:0] i_fetch_addr,
	output logic o_fetch_refused,
	input wire protected_page_pkg::reset_cause_s i_reset_cause,
	output logic o_port6_reset,
	output logic o_reset_pin_select,
	output logic o_debug_port_enable
);
	protected_page_pkg::state_s s_q;
	protected_page_pkg::state_s s_d;
	logic [7:0] page_value;
	logic page_hit;

	function automatic logic [3:0] divide_ratio(input logic [1:0] code);
		case (code)
			2'h0: divide_ratio = 4'h1;
			2'h1: divide_ratio = 4'h2;
			2'h2: divide_ratio = 4'h4;
			default: divide_ratio = 4'h8;
		endcase
	endfunction : divide_ratio

	function automatic logic [7:0] control_byte(
		input protected_page_pkg::state_s s);
		control_byte = {s.access_enable, s.soft_boot, s.soft_reset,
			s.command_fail, 4'h0};
	endfunction : control_byte

	// page read view; bits a page write does not keep read as zero, except divider bit 1 and brownout bit 0, which read as one
	always_comb begin
		page_hit = 1'b1;
		case (s_q.addr_low)
			`PG_IAP_LOW_BOUNDARY: page_value = {s_q.iap_low_boundary, 1'b0};
			`PG_CLOCK_SOURCE: page_value = s_q.clock_source;
			`PG_CLOCK_DIVIDER: page_value = {4'h0, s_q.system_clock_divider,
				2'h2};
			`PG_BROWNOUT: page_value = s_q.brownout | `BROWNOUT_FIXED;
			`PG_WRITE_LOCK: page_value = s_q.write_lock;
			`PG_DEVICE: page_value = s_q.device;
			default: begin
				page_value = 8'h00;
				page_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		s_d = s_q;
		s_d.soft_reset = 1'b0;
		s_d.flag_meta = {i_detector2_flag, i_detector1_flag};
		s_d.flag_sync = s_q.flag_meta;
		if (!s_q.opt_loaded) begin
			s_d.brownout[5:4] = i_opt_detector2_level;
			s_d.opt_loaded = 1'b1;
		end
		if (i_sfr_we && s_q.phase != protected_page_pkg::ST_BUSY) begin
			case (i_sfr_addr)
				`SFR_PORT_DATA: s_d.port_data = i_sfr_wdata;
				`SFR_PORT_ADDR_HIGH: s_d.addr_high = i_sfr_wdata;
				`SFR_PORT_ADDR_LOW: s_d.addr_low = i_sfr_wdata;
				`SFR_FLASH_MODE: s_d.mode = i_sfr_wdata[2:0];
				`SFR_FLASH_CONTROL: begin
					s_d.access_enable = i_sfr_wdata[`BIT_ACCESS_ENABLE];
					s_d.soft_boot = i_sfr_wdata[`BIT_SOFT_BOOT];
					s_d.soft_reset = i_sfr_wdata[`BIT_SOFT_RESET];
					s_d.command_fail = i_sfr_wdata[`BIT_COMMAND_FAIL];
				end
				`SFR_COMMAND_KEY: begin
					if (i_sfr_wdata == `KEY_FIRST) begin
						s_d.phase = protected_page_pkg::ST_ARMED;
					end else if (s_q.phase == protected_page_pkg::ST_ARMED &&
						i_sfr_wdata == `KEY_SECOND) begin
						if (s_q.access_enable) begin
							s_d.phase = protected_page_pkg::ST_BUSY;
						end else begin
							s_d.phase = protected_page_pkg::ST_IDLE;
							s_d.command_fail = 1'b1;
						end
					end else begin
						s_d.phase = protected_page_pkg::ST_IDLE;
					end
				end
				default: begin
				end
			endcase
		end
		// the operation runs while the processor is held
		if (s_q.phase == protected_page_pkg::ST_BUSY) begin
			s_d.phase = protected_page_pkg::ST_IDLE;
			s_d.command_fail = 1'b1;
			if (s_q.addr_high == `PAGE_ADDR_HIGH && page_hit) begin
				if (s_q.mode == `MODE_PAGE_READ) begin
					s_d.port_data = page_value;
					s_d.command_fail = 1'b0;
				end else if (s_q.mode == `MODE_PAGE_WRITE) begin
					s_d.command_fail = 1'b0;
					case (s_q.addr_low)
						`PG_IAP_LOW_BOUNDARY:
							s_d.iap_low_boundary = s_q.port_data[7:1];
						`PG_CLOCK_SOURCE: s_d.clock_source = s_q.port_data;
						`PG_CLOCK_DIVIDER:
							s_d.system_clock_divider = s_q.port_data[3:2];
						`PG_BROWNOUT: begin
							s_d.brownout = s_q.port_data & 8'hbe;
							s_d.opt_loaded = 1'b1;
						end
						`PG_WRITE_LOCK: s_d.write_lock = s_q.port_data;
						`PG_DEVICE: s_d.device = s_q.port_data & 8'h47;
						default: begin
						end
					endcase
				end
			end
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q.phase <= protected_page_pkg::ST_IDLE;
			s_q.port_data <= `RST_PORT_DATA;
			s_q.addr_high <= 8'h00;
			s_q.addr_low <= 8'h00;
			s_q.mode <= 3'h0;
			s_q.access_enable <= 1'b0;
			s_q.soft_boot <= 1'b0;
			s_q.soft_reset <= 1'b0;
			s_q.command_fail <= 1'b0;
			s_q.iap_low_boundary <= `RST_IAP_LOW_BOUNDARY;
			s_q.clock_source <= `RST_CLOCK_SOURCE;
			s_q.system_clock_divider <= `RST_CLOCK_DIVIDER;
			s_q.brownout <= `RST_BROWNOUT & 8'hbe;
			s_q.write_lock <= `RST_WRITE_LOCK;
			s_q.device <= `RST_DEVICE;
			s_q.opt_loaded <= 1'b0;
			s_q.flag_meta <= 2'h0;
			s_q.flag_sync <= 2'h0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		case (i_sfr_addr)
			`SFR_PORT_DATA: o_sfr_rdata = s_q.port_data;
			`SFR_PORT_ADDR_HIGH: o_sfr_rdata = s_q.addr_high;
			`SFR_PORT_ADDR_LOW: o_sfr_rdata = s_q.addr_low;
			`SFR_FLASH_MODE: o_sfr_rdata = {5'h00, s_q.mode};
			`SFR_FLASH_CONTROL: o_sfr_rdata = control_byte(s_q);
			default: o_sfr_rdata = 8'h00;
		endcase
	end

	assign o_cpu_stall = (s_q.phase == protected_page_pkg::ST_BUSY);
	assign o_soft_reset = s_q.soft_reset;
	assign o_soft_boot = s_q.soft_boot;
	assign o_iap_low_addr = {s_q.iap_low_boundary, 1'b0, 8'h00};
	assign o_iap_high_addr = i_isp_start - 16'h0001;
	assign o_iap_bound_error = o_iap_low_addr > i_isp_start;
	assign o_crystal_gain = s_q.clock_source[7:6];
	assign o_crystal_enable = s_q.clock_source[5];
	assign o_port6_xtal_gpio = ~s_q.clock_source[5];
	assign o_fast_rc_enable = s_q.clock_source[4];
	assign o_master_clock_source = s_q.clock_source[3:2];
	// any multiplied source keeps the multiplier running
	assign o_multiplier_enable = |s_q.clock_source[3:2];
	assign o_oscillator_select = 4'h1 << s_q.clock_source[1:0];
	assign o_system_clock_divide =
		divide_ratio(s_q.system_clock_divider);
	assign o_detector2_level = s_q.brownout[5:4];
	assign o_detector2_run = s_q.brownout[2] &
		(~i_power_down | s_q.brownout[7]);
	assign o_brownout_reset = (s_q.flag_sync[0] & s_q.brownout[1]) |
		(s_q.flag_sync[1] & s_q.brownout[3]);
	assign o_guarded_write_allow = i_guarded_write & ~s_q.write_lock;
	assign o_fetch_refused = s_q.device[6] & i_fetch_valid &
		(i_fetch_addr >= o_iap_low_addr) &
		(i_fetch_addr < i_isp_start);
	assign o_port6_reset = s_q.device[2] ?
		(i_reset_cause.por | i_reset_cause.ext | o_brownout_reset) :
		(i_reset_cause.por | i_reset_cause.ext | i_reset_cause.other |
		o_brownout_reset);
	assign o_reset_pin_select = s_q.device[1];
	assign o_debug_port_enable = s_q.device[0];

	property p_busy_one_cycle;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_cpu_stall |=> !o_cpu_stall;
	endproperty
	a_busy_one_cycle: assert property (p_busy_one_cycle)
		else $error("stall longer than one cycle");

	property p_trigger;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(s_q.phase == protected_page_pkg::ST_ARMED && i_sfr_we &&
		i_sfr_addr == `SFR_COMMAND_KEY && i_sfr_wdata == `KEY_SECOND &&
		s_q.access_enable) |=> o_cpu_stall;
	endproperty
	a_trigger: assert property (p_trigger)
		else $error("key pair did not start operation");

	property p_no_enable;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(i_sfr_we && i_sfr_addr == `SFR_COMMAND_KEY &&
		i_sfr_wdata == `KEY_SECOND && !s_q.access_enable &&
		s_q.phase == protected_page_pkg::ST_ARMED) |=>
		(!o_cpu_stall && s_q.command_fail);
	endproperty
	a_no_enable: assert property (p_no_enable)
		else $error("operation ran without access enable");

	property p_bad_key;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(s_q.phase == protected_page_pkg::ST_ARMED && i_sfr_we &&
		i_sfr_addr == `SFR_COMMAND_KEY && i_sfr_wdata != `KEY_SECOND &&
		i_sfr_wdata != `KEY_FIRST) |=>
		s_q.phase == protected_page_pkg::ST_IDLE;
	endproperty
	a_bad_key: assert property (p_bad_key)
		else $error("wrong key kept sequence");

	property p_read_result;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_cpu_stall && s_q.mode == `MODE_PAGE_READ && page_hit &&
		s_q.addr_high == `PAGE_ADDR_HIGH) |=>
		(s_q.port_data == $past(page_value) && !s_q.command_fail);
	endproperty
	a_read_result: assert property (p_read_result)
		else $error("page read result wrong");

	property p_write_lock;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_cpu_stall && s_q.mode == `MODE_PAGE_WRITE &&
		s_q.addr_low == `PG_WRITE_LOCK && s_q.addr_high == `PAGE_ADDR_HIGH)
		|=> s_q.write_lock == $past(s_q.port_data);
	endproperty
	a_write_lock: assert property (p_write_lock)
		else $error("page write not stored");

	property p_guard;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_guarded_write_allow & s_q.write_lock) == 8'h00;
	endproperty
	a_guard: assert property (p_guard)
		else $error("locked register writable");

	property p_bor;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(!s_q.brownout[1] && !s_q.brownout[3]) |-> !o_brownout_reset;
	endproperty
	a_bor: assert property (p_bor)
		else $error("disabled detector caused reset");

	property p_low_addr;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		o_iap_low_addr[7:0] == 8'h00 &&
		o_iap_low_addr[15:9] == s_q.iap_low_boundary;
	endproperty
	a_low_addr: assert property (p_low_addr)
		else $error("region low address wrong");

	property p_port6;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(s_q.device[2] && i_reset_cause.other && !i_reset_cause.por &&
		!i_reset_cause.ext && !o_brownout_reset) |-> !o_port6_reset;
	endproperty
	a_port6: assert property (p_port6)
		else $error("port6 reset outside scope");

	property p_write_ok;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_cpu_stall && s_q.mode == `MODE_PAGE_WRITE && page_hit &&
		s_q.addr_high == `PAGE_ADDR_HIGH) |=> !s_q.command_fail;
	endproperty
	a_write_ok: assert property (p_write_ok)
		else $error("successful page write flagged as failed");

	property p_bad_high;
		@(posedge i_core_clk) disable iff (!i_rst_n)
		(o_cpu_stall && s_q.addr_high != `PAGE_ADDR_HIGH) |=>
		(s_q.command_fail && s_q.write_lock == $past(s_q.write_lock));
	endproperty
	a_bad_high: assert property (p_bad_high)
		else $error("page operation ran with nonzero high address");
endmodule : protected_sfr_page_access
`default_nettype wire

// file: protected_sfr_page_access_tb.sv
// self-checking bench of the protected page access block
`timescale 1ns/1ps
`default_nettype none
`include "protected_page_map.svh"
module protected_sfr_page_access_tb;
	logic clk, rst_n, we, fv, pd, f1, f2;
	logic [7:0] addr, wd, rdata, gw, gwa, rv;
	logic [15:0] isp, fa, lo, hi;
	logic [1:0] opt, gain, mcs, lvl;
	logic [3:0] osel, dv;
	protected_page_pkg::reset_cause_s rc;
	logic stall, berr, xen, p6g, frc, men, run, bor, fref, p6r, rps, dbg;
	logic srst, sboot;
	int miscompares, total_checks;

	protected_sfr_page_access i_dut (
		.i_core_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr),
		.i_sfr_we(we), .i_sfr_wdata(wd), .o_sfr_rdata(rdata),
		.o_cpu_stall(stall), .o_soft_reset(srst), .o_soft_boot(sboot),
		.i_isp_start(isp), .o_iap_low_addr(lo), .o_iap_high_addr(hi),
		.o_iap_bound_error(berr), .o_crystal_gain(gain),
		.o_crystal_enable(xen), .o_port6_xtal_gpio(p6g),
		.o_fast_rc_enable(frc), .o_master_clock_source(mcs),
		.o_multiplier_enable(men), .o_oscillator_select(osel),
		.o_system_clock_divide(dv), .i_opt_detector2_level(opt),
		.i_detector1_flag(f1), .i_detector2_flag(f2),
		.i_power_down(pd), .o_detector2_level(lvl),
		.o_detector2_run(run), .o_brownout_reset(bor),
		.i_guarded_write(gw), .o_guarded_write_allow(gwa),
		.i_fetch_valid(fv), .i_fetch_addr(fa), .o_fetch_refused(fref),
		.i_reset_cause(rc), .o_port6_reset(p6r),
		.o_reset_pin_select(rps), .o_debug_port_enable(dbg)
	);

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
			miscompares++;
		end
	endtask : chk

	task automatic give_verdict();
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : give_verdict

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		we <= 1'b1;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		we <= 1'b0;
		#1 rv = rdata;
	endtask : rd

	task automatic setup(input logic [7:0] h, input logic [7:0] i,
		input logic [7:0] d, input logic [2:0] m, input logic en);
		wr(`SFR_PORT_ADDR_HIGH, h);
		wr(`SFR_PORT_ADDR_LOW, i);
		wr(`SFR_PORT_DATA, d);
		wr(`SFR_FLASH_MODE, {5'h00, m});
		wr(`SFR_FLASH_CONTROL, {en, 7'h00});
	endtask : setup

	// key pair, then the stall cycle and the cycle after it
	task automatic trig(input logic st, input logic ck);
		wr(`SFR_COMMAND_KEY, `KEY_FIRST);
		wr(`SFR_COMMAND_KEY, `KEY_SECOND);
		@(posedge clk);
		we <= 1'b0;
		#1 if (ck) chk(stall, st);
		@(posedge clk);
		#1 chk(stall, 1'b0);
	endtask : trig

	task automatic pw(input logic [7:0] i, input logic [7:0] d);
		setup(`PAGE_ADDR_HIGH, i, d, `MODE_PAGE_WRITE, 1'b1);
		trig(1'b1, 1'b1);
	endtask : pw

	task automatic chkpg(input logic [7:0] i, input logic [7:0] e);
		setup(`PAGE_ADDR_HIGH, i, 8'h00, `MODE_PAGE_READ, 1'b1);
		trig(1'b1, 1'b1);
		rd(`SFR_PORT_DATA);
		chk(rv, e);
	endtask : chkpg

	task automatic t_reset();
		rd(`SFR_PORT_DATA);
		chk(rv, `RST_PORT_DATA);
		chkpg(`PG_IAP_LOW_BOUNDARY, {`RST_IAP_LOW_BOUNDARY, 1'b0});
		chkpg(`PG_CLOCK_SOURCE, `RST_CLOCK_SOURCE);
		chkpg(`PG_CLOCK_DIVIDER, `CLOCK_DIV_FIXED);
		chkpg(`PG_BROWNOUT, (`RST_BROWNOUT & 8'hcf) | 8'h20);
		chkpg(`PG_WRITE_LOCK, `RST_WRITE_LOCK);
		chkpg(`PG_DEVICE, `RST_DEVICE);
		chk({rps, dbg}, 2'h3);
	endtask : t_reset

	task automatic t_clock();
		for (int k = 0; k < 4; k++) begin
			pw(`PG_CLOCK_SOURCE, {4'h6, k[1:0], k[1:0]});
			chk({gain, xen, p6g}, 4'h6);
			chk(mcs, k[1:0]);
			chk(men, k != 0);
			chk(osel, 4'h1 << k);
			pw(`PG_CLOCK_DIVIDER, `CLOCK_DIV_FIXED | (k[7:0] << 2));
			chk(dv, 4'h1 << k);
		end
		pw(`PG_CLOCK_SOURCE, 8'h50);
		repeat (`FAST_RC_SETTLE_CYCLES) @(posedge clk);
		chk({xen, p6g, frc}, 3'h3);
	endtask : t_clock

	task automatic t_iap();
		logic [15:0] fad [4];
		fad = '{16'h6000, 16'h6fff, 16'h7000, 16'h5fff};
		pw(`PG_IAP_LOW_BOUNDARY, 8'h61);
		chkpg(`PG_IAP_LOW_BOUNDARY, 8'h60);
		chk(lo, 16'h6000);
		chk(hi, 16'h6fff);
		chk(berr, 1'b0);
		pw(`PG_DEVICE, 8'h44);
		chkpg(`PG_DEVICE, 8'h44);
		chk({rps, dbg}, 2'h0);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			fv <= 1'b1;
			fa <= fad[k];
			#1 chk(fref, k < 2);
		end
		@(posedge clk);
		rc <= 3'b001;
		#1 chk(p6r, 1'b0);
		@(posedge clk);
		rc <= 3'b100;
		#1 chk(p6r, 1'b1);
		pw(`PG_DEVICE, 8'h00);
		@(posedge clk);
		fa <= 16'h6000;
		#1 chk(fref, 1'b0);
		@(posedge clk);
		rc <= 3'b001;
		#1 chk(p6r, 1'b1);
		pw(`PG_IAP_LOW_BOUNDARY, 8'h72);
		chk(lo, 16'h7200);
		chk(berr, 1'b1);
	endtask : t_iap

	task automatic t_brownout();
		pw(`PG_BROWNOUT, 8'h9e);
		chkpg(`PG_BROWNOUT, 8'h9f);
		chk({lvl, run}, 3'h3);
		@(posedge clk);
		pd <= 1'b1;
		#1 chk(run, 1'b1);
		pw(`PG_BROWNOUT, 8'h16);
		chk(run, 1'b0);
		@(posedge clk);
		pd <= 1'b0;
		f2 <= 1'b1;
		#1 chk(run, 1'b1);
		repeat (3) @(posedge clk);
		#1 chk(bor, 1'b0);
		@(posedge clk);
		f1 <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(bor, 1'b1);
		@(posedge clk);
		f1 <= 1'b0;
		pw(`PG_BROWNOUT, 8'h1c);
		chk(bor, 1'b1);
		@(posedge clk);
		f2 <= 1'b0;
		repeat (3) @(posedge clk);
		#1 chk(bor, 1'b0);
	endtask : t_brownout

	task automatic t_lock();
		pw(`PG_WRITE_LOCK, 8'ha5);
		chkpg(`PG_WRITE_LOCK, 8'ha5);
		@(posedge clk);
		gw <= 8'hff;
		#1 chk(gwa, 8'h5a);
	endtask : t_lock

	task automatic t_refuse();
		wr(`SFR_FLASH_CONTROL, 8'h60);
		@(posedge clk);
		we <= 1'b0;
		#1 chk({srst, sboot}, 2'h3);
		@(posedge clk);
		#1 chk({srst, sboot}, 2'h1);
		setup(`PAGE_ADDR_HIGH, `PG_WRITE_LOCK, 8'h33, `MODE_PAGE_WRITE, 1'b0);
		trig(1'b0, 1'b1);
		rd(`SFR_FLASH_CONTROL);
		chk(rv[4], 1'b1);
		setup(`PAGE_ADDR_HIGH, `PG_WRITE_LOCK, 8'h33, `MODE_PAGE_WRITE, 1'b1);
		wr(`SFR_COMMAND_KEY, `KEY_FIRST);
		wr(`SFR_COMMAND_KEY, 8'h12);
		wr(`SFR_COMMAND_KEY, `KEY_SECOND);
		@(posedge clk);
		we <= 1'b0;
		#1 chk(stall, 1'b0);
		trig(1'b1, 1'b1);
		rd(`SFR_FLASH_CONTROL);
		chk(rv[4], 1'b0);
		chkpg(`PG_WRITE_LOCK, 8'h33);
		for (int k = 0; k < 3; k++) begin
			setup({7'h00, k == 0}, k == 2 ? 8'h50 : `PG_WRITE_LOCK, 8'h77,
				k == 1 ? 3'h1 : `MODE_PAGE_WRITE, 1'b1);
			trig(1'b0, 1'b0);
			rd(`SFR_FLASH_CONTROL);
			chk(rv[4], 1'b1);
		end
		chkpg(`PG_WRITE_LOCK, 8'h33);
	endtask : t_refuse

	initial begin
		rst_n = 1'b0;
		{we, fv, pd, f1, f2} = 5'h00;
		{addr, wd, gw} = 24'h000000;
		isp = 16'h7000;
		fa = 16'h0000;
		opt = 2'h2;
		rc = 3'b000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_clock();
		t_iap();
		t_brownout();
		t_lock();
		t_refuse();
		give_verdict();
	end
endmodule : protected_sfr_page_access_tb
`default_nettype wire
